// file: logic/cpcd_device.sv
// decoder end: pointer and setup read commands on the serial link clock
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cpcd_params.svh"

module cpcd_device
  import cpcd_pkg::*;
#(
  parameter logic [11:0] SETUP_RESET = `CPCD_SETUP_RESET
) (
  cpcd_spi_if.device LINK,             // serial link, clocked by its sclk
  input wire logic RST,                // reset, sync to link clock, high
  input wire logic PLAYING,            // playback engine active (pin)
  input wire logic POWERED,            // device powered up (pin)
  input wire logic LAYOUT_CIRCULAR,    // stored layout is circular (pin)
  input wire logic [10:0] LAST_MSG_ROW,  // start row of last message
  input wire logic [10:0] FREE_ROW,      // first unused row
  input wire logic [10:0] NEXT_MSG_ROW,  // start row after current message
  output logic [10:0] PLAYBACK_POSITION, // playback position register
  output logic [10:0] RECORD_POSITION,   // record position register
  output logic [11:0] ANALOG_SETUP,      // analog path setup register
  output logic CMD_ERROR,                // command error flag
  output logic CHECKED                   // layout check has passed
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  cpcd_dev_state_t state;
  logic [2:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] rx;
  logic [7:0] opcode;
  logic [7:0] tx;
  logic [10:0] playback_position;
  logic [10:0] record_position;
  logic [11:0] analog_path_setup;
  logic cmd_err;
  logic checked;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic playing_s;
  logic powered_s;
  logic layout_s;
  logic [7:0] next_rx_byte;
  logic [7:0] status_lo;
  logic byte_done;
  logic exec_now;
  logic busy_err;
  logic [32:0] row_meta;
  logic [32:0] row_sync;

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  // the engine levels come from another domain; two flops each, first read by second only
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always_ff @(posedge LINK.sclk) begin
        if (RST) begin
          pin_meta[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
        end else begin
          pin_meta[g] <= (g == 0) ? PLAYING : ((g == 1) ? POWERED : LAYOUT_CIRCULAR);
          pin_sync[g] <= pin_meta[g];
        end
      end
    end
  endgenerate

  assign playing_s = pin_sync[0];
  assign powered_s = pin_sync[1];
  assign layout_s = pin_sync[2];

  // rows are quasi-static but come from another domain; settled long before use
  always_ff @(posedge LINK.sclk) begin
    row_meta <= {LAST_MSG_ROW, FREE_ROW, NEXT_MSG_ROW};
    row_sync <= row_meta;
  end

  // ----------------------------------------------------------------------------
  // byte framing
  // ----------------------------------------------------------------------------
  // data arrive lsb first, so each new bit enters at the top
  assign next_rx_byte = {LINK.mosi, rx[7:1]};
  assign byte_done = (state == CPCD_DEV_FRAME) && (bit_cnt == 3'd7);
  // commands act once the second byte has been clocked in
  assign exec_now = byte_done && (byte_idx == 2'd1);
  // all five known commands raise the error flag while playing, reads still answer; other opcodes leave the error flag alone
  assign busy_err = playing_s;

  // first status word, low byte
  always_comb begin
    status_lo = 8'h00;
    status_lo[`CPCD_ST_CMD_ERR] = cmd_err;
    status_lo[`CPCD_ST_PLAYING] = playing_s;
    status_lo[`CPCD_ST_POWERED] = powered_s;
    status_lo[`CPCD_ST_CHECKED] = checked;
  end

  // frame phase and bit counters; ss_n high drops any partial frame
  always_ff @(posedge LINK.sclk) begin
    if (RST) begin
      state <= CPCD_DEV_IDLE;
      bit_cnt <= 3'd0;
      byte_idx <= 2'd0;
      rx <= 8'h00;
      opcode <= 8'h00;
    end else if (LINK.ss_n) begin
      state <= CPCD_DEV_IDLE;
      bit_cnt <= 3'd0;
      byte_idx <= 2'd0;
    end else begin
      state <= CPCD_DEV_FRAME;
      bit_cnt <= bit_cnt + 3'd1;
      rx <= next_rx_byte;
      if (bit_cnt == 3'd7) begin
        byte_idx <= byte_idx + 2'd1;
        if (byte_idx == 2'd0) begin
          opcode <= next_rx_byte;
        end
      end
    end
  end

  // the frame branch also covers the very first edge of a frame
  // because ss_n is seen low there while state still reads idle

  // ----------------------------------------------------------------------------
  // answer shifter
  // ----------------------------------------------------------------------------
  // the next byte is loaded on the edge that completes the current one, so its
  // first bit is already on the line before the host samples it
  always_ff @(posedge LINK.sclk) begin
    if (RST) begin
      tx <= 8'h00;
    end else if (LINK.ss_n) begin
      tx <= status_lo;
    end else if (bit_cnt == 3'd7) begin
      case (byte_idx)
        2'd0: tx <= 8'h00;
        2'd1: begin
          case (opcode)
            `CPCD_OP_RD_PLAY: tx <= playback_position[7:0];
            `CPCD_OP_RD_REC: tx <= record_position[7:0];
            `CPCD_OP_RD_SETUP: tx <= analog_path_setup[7:0];
            default: tx <= 8'h00;
          endcase
        end
        2'd2: begin
          case (opcode)
            `CPCD_OP_RD_PLAY: tx <= {5'h00, playback_position[10:8]};
            `CPCD_OP_RD_REC: tx <= {5'h00, record_position[10:8]};
            `CPCD_OP_RD_SETUP: tx <= {4'h0, analog_path_setup[11:8]};
            default: tx <= 8'h00;
          endcase
        end
        default: tx <= 8'h00;
      endcase
    end else begin
      tx <= {1'b0, tx[7:1]};
    end
  end

  assign LINK.miso = tx[0];

  // ----------------------------------------------------------------------------
  // command execution
  // ----------------------------------------------------------------------------
  // the pointers and the flag move only here; read commands only raise the error flag while playing, other opcodes fall to default
  always_ff @(posedge LINK.sclk) begin
    if (RST) begin
      playback_position <= `CPCD_POS_RESET;
      record_position <= `CPCD_POS_RESET;
      cmd_err <= 1'b0;
      checked <= 1'b0;
    end else if (exec_now) begin
      case (opcode)
        `CPCD_OP_ADVANCE: begin
          if (busy_err) begin
            cmd_err <= 1'b1;
          end else if (!layout_s) begin
            cmd_err <= 1'b1;
          end else begin
            playback_position <= row_sync[10:0];
            cmd_err <= 1'b0;
          end
        end
        `CPCD_OP_CHECK: begin
          if (busy_err || !powered_s) begin
            cmd_err <= 1'b1;
          end else if (!layout_s) begin
            cmd_err <= 1'b1;
            checked <= 1'b0;
          end else begin
            playback_position <= row_sync[32:22];
            record_position <= row_sync[21:11];
            checked <= 1'b1;
            cmd_err <= 1'b0;
          end
        end
        `CPCD_OP_RD_PLAY, `CPCD_OP_RD_REC, `CPCD_OP_RD_SETUP: begin
          if (busy_err) begin
            cmd_err <= 1'b1;
          end
        end
        default: begin
          cmd_err <= cmd_err;
        end
      endcase
    end
  end

  // setup register: no command writes it, held at reset value
  always_ff @(posedge LINK.sclk) begin
    if (RST) begin
      analog_path_setup <= SETUP_RESET;
    end else begin
      analog_path_setup <= analog_path_setup;
    end
  end

  // ----------------------------------------------------------------------------
  // user side outputs
  // ----------------------------------------------------------------------------
  assign PLAYBACK_POSITION = playback_position;
  assign RECORD_POSITION = record_position;
  assign ANALOG_SETUP = analog_path_setup;
  assign CMD_ERROR = cmd_err;
  assign CHECKED = checked;

endmodule
`default_nettype wire

// file: logic/cpcd_host.sv
// controller end: register-driven frame sender with its own link clock divider
`timescale 1ns/1ps
`default_nettype none
`include "cpcd_params.svh"
module cpcd_host
  import cpcd_pkg::*;
#(
  parameter int HALF_CYCLES = `CPCD_HALF_CYCLES
) (
  input wire logic CLOCK,            // system clock
  input wire logic RST,              // sync reset, high
  input wire logic AWVALID,          // write address valid
  output logic AWREADY,              // write address ready
  input wire logic [3:0] AWADDR,     // write address
  input wire logic WVALID,           // write data valid
  output logic WREADY,               // write data ready
  input wire logic [31:0] WDATA,     // write data
  input wire logic [3:0] WSTRB,      // write strobes
  output logic BVALID,               // write response valid
  input wire logic BREADY,           // write response ready
  output logic [1:0] BRESP,          // write response
  input wire logic ARVALID,          // read address valid
  output logic ARREADY,              // read address ready
  input wire logic [3:0] ARADDR,     // read address
  output logic RVALID,               // read data valid
  input wire logic RREADY,           // read data ready
  output logic [31:0] RDATA,         // read data
  output logic [1:0] RRESP,          // read response
  cpcd_spi_if.host LINK              // serial link
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  cpcd_host_state_t state;
  logic [7:0] half_cnt;
  logic sclk;
  logic fall_evt;
  logic miso_meta;
  logic miso_s;
  logic go;
  logic [7:0] opcode;
  logic [5:0] bit_idx;
  logic [31:0] rxdata;
  logic done;
  logic aw_got;
  logic w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_now;
  logic ctrl_wr;
  logic done_clr;

  // ----------------------------------------------------------------------------
  // link clock divider
  // ----------------------------------------------------------------------------
  // runs free so the decoder always has edges for its reset and idle load
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      half_cnt <= 8'h00;
      sclk <= 1'b0;
    end else if (half_cnt == 8'(HALF_CYCLES - 1)) begin
      half_cnt <= 8'h00;
      sclk <= ~sclk;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  assign fall_evt = (half_cnt == 8'(HALF_CYCLES - 1)) && sclk;
  assign LINK.sclk = sclk;

  // answer pin passes two flops before sampling
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      miso_meta <= 1'b0;
      miso_s <= 1'b0;
    end else begin
      miso_meta <= LINK.miso;
      miso_s <= miso_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------------------
  // bits change at the falling point; fill bytes after the opcode are zero
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state <= CPCD_HOST_IDLE;
      LINK.ss_n <= 1'b1;
      LINK.mosi <= 1'b0;
      bit_idx <= 6'd0;
      rxdata <= 32'h0000_0000;
    end else if (fall_evt) begin
      case (state)
        CPCD_HOST_IDLE: begin
          if (go) begin
            state <= CPCD_HOST_RUN;
            LINK.ss_n <= 1'b0;
            LINK.mosi <= opcode[0];
            rxdata <= {31'h0000_0000, miso_s};
            bit_idx <= 6'd1;
          end
        end
        CPCD_HOST_RUN: begin
          if (bit_idx == cpcd_frame_bits(opcode)) begin
            state <= CPCD_HOST_IDLE;
            LINK.ss_n <= 1'b1;
            LINK.mosi <= 1'b0;
          end else begin
            rxdata[bit_idx[4:0]] <= miso_s;
            LINK.mosi <= (bit_idx < 6'd8) ? opcode[bit_idx[2:0]] : 1'b0;
            bit_idx <= bit_idx + 6'd1;
          end
        end
        default: state <= CPCD_HOST_IDLE;
      endcase
    end
  end

  // start request: new frames only from idle, one at a time
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      go <= 1'b0;
      opcode <= 8'h00;
    end else if (ctrl_wr && !go && state == CPCD_HOST_IDLE) begin
      go <= 1'b1;
      opcode <= w_data[7:0];
    end else if (fall_evt && state == CPCD_HOST_IDLE) begin
      go <= 1'b0;
    end
  end

  // done flag: frame end wins over a software clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      done <= 1'b0;
    end else if (fall_evt && state == CPCD_HOST_RUN && bit_idx == cpcd_frame_bits(opcode)) begin
      done <= 1'b1;
    end else if (done_clr) begin
      done <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------------------
  assign AWREADY = !aw_got && !BVALID;
  assign WREADY = !w_got && !BVALID;
  assign ARREADY = !RVALID;
  assign wr_now = aw_got && w_got && !BVALID;
  assign ctrl_wr = wr_now && aw_addr == `CPCD_REG_CTRL && w_strb[0];
  assign done_clr = wr_now && aw_addr == `CPCD_REG_STATUS && w_strb[0] && w_data[`CPCD_STAT_DONE];

  // address and data may come in either order
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= 2'b00;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (wr_now) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (aw_addr == `CPCD_REG_CTRL || aw_addr == `CPCD_REG_STATUS) ? 2'b00 : 2'b10;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= 2'b00;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP <= 2'b00;
      case (ARADDR)
        `CPCD_REG_CTRL: RDATA <= {24'h00_0000, opcode};
        `CPCD_REG_STATUS: RDATA <= {30'h0000_0000, done, go || state == CPCD_HOST_RUN};
        `CPCD_REG_RXDATA: RDATA <= rxdata;
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= 2'b10;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: logic/cpcd_params.svh
// constants for the circular pointer command decoder: opcodes, offsets, resets, timing
`ifndef CPCD_PARAMS_SVH
`define CPCD_PARAMS_SVH

// ----------------------------------------------------------------------------
// link opcodes
// ----------------------------------------------------------------------------
`define CPCD_OP_ADVANCE 8'h48
`define CPCD_OP_CHECK 8'h49
`define CPCD_OP_RD_PLAY 8'h06
`define CPCD_OP_RD_REC 8'h08
`define CPCD_OP_RD_SETUP 8'h44
`define CPCD_FILL_BYTE 8'h00

// ----------------------------------------------------------------------------
// frame lengths in bytes
// ----------------------------------------------------------------------------
`define CPCD_SHORT_BYTES 2
`define CPCD_LONG_BYTES 4

// ----------------------------------------------------------------------------
// first status word field positions
// ----------------------------------------------------------------------------
`define CPCD_ST_CMD_ERR 0
`define CPCD_ST_PLAYING 1
`define CPCD_ST_POWERED 2
`define CPCD_ST_CHECKED 3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CPCD_SETUP_RESET 12'h000
`define CPCD_POS_RESET 11'h000

// ----------------------------------------------------------------------------
// controller register offsets (byte addresses) and fields
// ----------------------------------------------------------------------------
`define CPCD_REG_CTRL 4'h0
`define CPCD_REG_STATUS 4'h4
`define CPCD_REG_RXDATA 4'h8
`define CPCD_STAT_BUSY 0
`define CPCD_STAT_DONE 1

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CPCD_CLK_PERIOD_NS 20
`define CPCD_LINK_PERIOD_NS 160
`define CPCD_HALF_CYCLES (`CPCD_LINK_PERIOD_NS / (2 * `CPCD_CLK_PERIOD_NS))

`endif

// file: logic/cpcd_pkg.sv
// types shared by both ends of the circular pointer command decoder
`default_nettype none
`include "cpcd_params.svh"
package cpcd_pkg;

  // device frame phase
  typedef enum logic [1:0] {
    CPCD_DEV_IDLE = 2'b01,
    CPCD_DEV_FRAME = 2'b10
  } cpcd_dev_state_t;

  // controller frame phase
  typedef enum logic [1:0] {
    CPCD_HOST_IDLE = 2'b01,
    CPCD_HOST_RUN = 2'b10
  } cpcd_host_state_t;

  // frame length in bits for an opcode
  function automatic logic [5:0] cpcd_frame_bits(input logic [7:0] op);
    logic [5:0] n;
    n = 6'(`CPCD_LONG_BYTES * 8);
    if (op == `CPCD_OP_ADVANCE || op == `CPCD_OP_CHECK) begin
      n = 6'(`CPCD_SHORT_BYTES * 8);
    end
    return n;
  endfunction

endpackage
`default_nettype wire

// file: logic/cpcd_spi_if.sv
// serial link between the controller and the decoder
`timescale 1ns/1ps
`default_nettype none
interface cpcd_spi_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso;

  modport host (output sclk, output ss_n, output mosi, input miso);
  modport device (input sclk, input ss_n, input mosi, output miso);
endinterface
`default_nettype wire

// file: verification/cpcd_link_properties.sv
// checker of the serial link between the controller and the decoder
`timescale 1ns/1ps
`default_nettype none
`include "cpcd_params.svh"
module cpcd_link_properties (
  input wire logic sclk, // link clock
  input wire logic ss_n, // frame select, active low
  input wire logic mosi, // controller to decoder data
  input wire logic miso, // decoder to controller data
  input wire logic RST   // decoder reset
);
  logic [6:0] cnt;
  logic [7:0] op;
  wire short_op = op == `CPCD_OP_ADVANCE || op == `CPCD_OP_CHECK;

  // ---------------------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------------------
  // bit count within a frame, on the decoder's sampling edge
  always_ff @(posedge sclk) begin
    if (RST || ss_n) begin
      cnt <= 7'h00;
    end else begin
      cnt <= cnt + 7'h01;
    end
  end
  // opcode capture, lsb first; held until the next frame overwrites it
  always_ff @(posedge sclk) begin
    if (!ss_n && cnt < 7'h08) begin
      op[cnt[2:0]] <= mosi;
    end
  end

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking @(posedge sclk); endclocking
  default disable iff (RST);
  sequence frame_start;
    $fell(ss_n);
  endsequence
  // cnt is non-zero only when a real frame has just closed
  sequence frame_end;
    $rose(ss_n) && cnt != 7'h00;
  endsequence

  a_short_frame_len: assert property (frame_end |-> !short_op || cnt == 7'h10)
    else $error("short frame has wrong bit count");
  a_long_frame_len: assert property (frame_end |-> short_op || cnt == 7'h20)
    else $error("long frame has wrong bit count");
  a_frame_gap_idle: assert property (frame_end |=> ss_n)
    else $error("select low again without an idle period");
  a_frame_select_held: assert property (frame_start |-> !ss_n [*8])
    else $error("select released early in a frame");
  a_status_high_zero: assert property (!ss_n && cnt >= 7'h08 && cnt < 7'h10 |-> !miso)
    else $error("status word high byte not zero");
  a_play_pad_zero: assert property (
    !ss_n && op == `CPCD_OP_RD_PLAY && cnt >= 7'h1b |-> !miso)
    else $error("playback position padding not zero");
  a_rec_pad_zero: assert property (
    !ss_n && op == `CPCD_OP_RD_REC && cnt >= 7'h1b |-> !miso)
    else $error("record position padding not zero");
  a_setup_pad_zero: assert property (
    !ss_n && op == `CPCD_OP_RD_SETUP && cnt >= 7'h1c |-> !miso)
    else $error("analog setup padding not zero");
endmodule
`default_nettype wire

// file: verification/test_circular_pointer_cmd_decoder.sv
// self-checking bench: controller and decoder joined over the serial link
`timescale 1ns/1ps
`default_nettype none
`include "cpcd_params.svh"
module test_circular_pointer_cmd_decoder;
  logic clock = 1'h0, host_rst = 1'h1, dev_rst = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rx;
  logic awready, wready, bvalid, arready, rvalid, cmd_err, chk;
  logic [1:0] bresp, rresp, r;
  logic playing = 1'h0, powered = 1'h1, circ = 1'h1;
  logic [10:0] last_row = 11'h0, free_row = 11'h0, next_row = 11'h0, pp, rp, m_pp, m_rp;
  logic [11:0] setup;
  logic m_err, m_chk;
  logic [7:0] ops [5] = '{`CPCD_OP_ADVANCE, `CPCD_OP_CHECK, `CPCD_OP_RD_PLAY,
    `CPCD_OP_RD_REC, `CPCD_OP_RD_SETUP};
  int failures = 0, checked = 0, seed = 5682;

  cpcd_spi_if link ();
  cpcd_host #(.HALF_CYCLES(4)) i_cpcd_host (.CLOCK(clock), .RST(host_rst),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready),
    .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
    .RDATA(rdata), .RRESP(rresp), .LINK(link));
  cpcd_device i_cpcd_device (.LINK(link), .RST(dev_rst), .PLAYING(playing),
    .POWERED(powered), .LAYOUT_CIRCULAR(circ), .LAST_MSG_ROW(last_row), .FREE_ROW(free_row),
    .NEXT_MSG_ROW(next_row), .PLAYBACK_POSITION(pp), .RECORD_POSITION(rp),
    .ANALOG_SETUP(setup), .CMD_ERROR(cmd_err), .CHECKED(chk));
  cpcd_link_properties i_cpcd_link_properties (.sclk(link.sclk), .ss_n(link.ss_n),
    .mosi(link.mosi), .miso(link.miso), .RST(dev_rst));

  // 50 MHz system clock; the link clock comes from the controller's divider
  always #10 clock = ~clock;

  // ---------------------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    failures++;
    summarize();
  endtask

  // ---------------------------------------------------------------------------
  // register bus and frame tasks
  // ---------------------------------------------------------------------------
  // leading edge keeps two tasks from assigning one handshake signal in a step
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] re);
    int n;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (bvalid !== 1'h1 && n < 300) begin
      @(posedge clock);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end
    re = bresp;
    bready <= 1'h0;
    if (n >= 300) hang();
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] re);
    int n;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (rvalid !== 1'h1 && n < 300) begin
      @(posedge clock);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end
    d = rdata;
    re = rresp;
    rready <= 1'h0;
    if (n >= 300) hang();
  endtask
  // start a frame, poll for its end, fetch what came back, clear done
  task automatic run_frame(input logic [7:0] op, output logic [31:0] got);
    int n;
    n = 0;
    axi_write(`CPCD_REG_CTRL, {24'h0, op}, r);
    check("ctrl bresp", {30'h0, r}, 32'h0);
    got = 32'h0;
    while (got[`CPCD_STAT_DONE] !== 1'h1 && n < 200) begin
      axi_read(`CPCD_REG_STATUS, got, r);
      n++;
    end
    if (n >= 200) hang();
    axi_read(`CPCD_REG_CTRL, got, r);
    check("ctrl opcode", got, {24'h0, op});
    axi_read(`CPCD_REG_RXDATA, got, r);
    axi_write(`CPCD_REG_STATUS, 32'h2, r);
  endtask
  // new pin levels and rows; the wait covers the decoder's synchronisers
  task automatic set_in(input logic p, input logic pw, input logic c);
    @(posedge clock);
    playing <= p;
    powered <= pw;
    circ <= c;
    last_row <= 11'($random(seed));
    free_row <= 11'($random(seed));
    next_row <= 11'($random(seed));
    repeat (40) @(posedge clock);
  endtask

  // ---------------------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] expect_rx(input logic [7:0] op);
    logic [31:0] e;
    e = {28'h0, m_chk, powered, playing, m_err};
    if (op == `CPCD_OP_RD_PLAY) e[26:16] = m_pp;
    if (op == `CPCD_OP_RD_REC) e[26:16] = m_rp;
    if (op == `CPCD_OP_RD_SETUP) e[27:16] = `CPCD_SETUP_RESET;
    return e;
  endfunction
  // status bits 7:4 are not modelled
  task automatic do_cmd(input logic [7:0] op);
    logic [31:0] exp;
    logic ok;
    exp = expect_rx(op);
    ok = !playing && circ && (powered || op != `CPCD_OP_CHECK);
    if (op == `CPCD_OP_CHECK || op == `CPCD_OP_ADVANCE) begin
      m_err = !ok;
    end else if (playing) begin
      m_err = 1'h1;
    end
    if (!playing && powered && !circ && op == `CPCD_OP_CHECK) m_chk = 1'h0;
    if (ok && op == `CPCD_OP_CHECK) begin
      m_pp = last_row;
      m_rp = free_row;
      m_chk = 1'h1;
    end
    if (ok && op == `CPCD_OP_ADVANCE) m_pp = next_row;
    run_frame(op, rx);
    check("frame", rx & 32'hffff_ff0f, exp);
    check("play pos", {21'h0, pp}, {21'h0, m_pp});
    check("rec pos", {21'h0, rp}, {21'h0, m_rp});
    check("cmd err", {31'h0, cmd_err}, {31'h0, m_err});
    check("setup", {20'h0, setup}, {20'h0, `CPCD_SETUP_RESET});
    check("checked", {31'h0, chk}, {31'h0, m_chk});
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    m_pp = 11'h0;
    m_rp = 11'h0;
    m_err = 1'h0;
    m_chk = 1'h0;
    repeat (16) @(posedge clock);
    host_rst <= 1'h0;
    repeat (3) @(negedge link.sclk);
    dev_rst <= 1'h0;
    repeat (4) @(negedge link.sclk);
    check("reset", {8'h0, rp, pp, cmd_err, chk}, 32'h0);
    axi_read(4'hc, rx, r);
    check("unmapped rdata", rx, 32'h0);
    check("unmapped rresp", {30'h0, r}, 32'h2);
    axi_write(4'hc, 32'h5, r);
    check("unmapped bresp", {30'h0, r}, 32'h2);
    $display("test bus done");
    do_cmd(`CPCD_OP_RD_SETUP);
    set_in(1'h0, 1'h0, 1'h1);
    do_cmd(`CPCD_OP_CHECK);
    set_in(1'h0, 1'h1, 1'h0);
    do_cmd(`CPCD_OP_CHECK);
    do_cmd(`CPCD_OP_ADVANCE);
    $display("test refusals done");
    set_in(1'h0, 1'h1, 1'h1);
    do_cmd(`CPCD_OP_CHECK);
    do_cmd(`CPCD_OP_RD_PLAY);
    for (int i = 0; i < 3; i++) begin
      set_in(1'h0, 1'h1, 1'h1);
      do_cmd(`CPCD_OP_ADVANCE);
      do_cmd(`CPCD_OP_RD_PLAY);
    end
    do_cmd(`CPCD_OP_RD_REC);
    $display("test stepping done");
    set_in(1'h1, 1'h1, 1'h1);
    do_cmd(`CPCD_OP_ADVANCE);
    do_cmd(`CPCD_OP_CHECK);
    do_cmd(`CPCD_OP_RD_REC);
    set_in(1'h0, 1'h1, 1'h1);
    do_cmd(`CPCD_OP_ADVANCE);
    $display("test playback done");
    for (int i = 0; i < 16; i++) begin
      set_in(($random(seed) & 7) == 0, ($random(seed) & 7) != 0, ($random(seed) & 3) != 0);
      do_cmd(ops[$unsigned($random(seed)) % 5]);
    end
    $display("test random done");
    summarize();
  end
endmodule
`default_nettype wire
